// File: design/exec_pkg.sv
package exec_pkg;

	// Instruction word layout and opcodes
	localparam int WORD_W = 16;
	localparam int PC_W = 21;
	localparam logic [3:0] OP_BIT_INVERT = 4'h7;
	localparam logic [7:0] OP_BRANCH_OVF = 8'he4;
	localparam logic [7:0] OP_BRANCH_ZERO = 8'he0;
	localparam logic [6:0] OP_CALL = 7'h76;
	localparam int BIT_SEL_HI = 11;
	localparam int BIT_SEL_LO = 9;
	localparam int ACCESS_POS = 8;
	localparam int SHADOW_POS = 8;

	// Data memory map
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

	// Flag positions inside the status byte
	localparam int ZERO_POS = 2;
	localparam int OVF_POS = 3;

	// Program counter steps in bytes
	localparam logic [PC_W-1:0] PC_STEP = 21'h00002;
	localparam logic [PC_W-1:0] CALL_RETURN_STEP = 21'h00004;
	localparam logic [PC_W-1:0] PC_RESET = 21'h00000;

	// Phase numbering within one instruction cycle
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q3 = 2'h2;
	localparam logic [1:0] PH_Q4 = 2'h3;

	typedef enum logic [1:0]
	{
		ST_EXEC = 2'b00,
		ST_FLUSH = 2'b01,
		ST_CALL2 = 2'b10
	} exec_state_t;

	// Live core registers used by shadowing and addressing
	typedef struct packed
	{
		logic [7:0] accumulator;
		logic [7:0] flags;
		logic [7:0] bank_select_reg;
	} core_regs_t;

endpackage

// File: design/exec_unit.sv
`timescale 1ns/1ps
`default_nettype none

module exec_unit
	import exec_pkg::*;
#(
	parameter int DATA_AW = 12
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [WORD_W-1:0] instr_word,
	input wire core_regs_t live_regs,
	input wire logic ext_enable,
	input wire logic [DATA_AW-1:0] index_base,
	input wire logic load_en,
	input wire logic [DATA_AW-1:0] load_addr,
	input wire logic [7:0] load_data,
	output logic [PC_W-1:0] pc,
	output logic [1:0] phase,
	output logic file_we,
	output logic [DATA_AW-1:0] file_addr,
	output logic [7:0] file_wdata,
	output logic stack_push,
	output logic [PC_W-1:0] stack_addr,
	output logic [7:0] accumulator_shadow,
	output logic [7:0] flags_shadow,
	output logic [7:0] bank_select_shadow
);

	generate
		if (DATA_AW != 12)
		begin : g_bad_width
			$error("DATA_AW must be 12: bank and offset fill the address");
		end
	endgenerate

	logic [7:0] general_purpose_file [0:(1<<DATA_AW)-1];
	exec_state_t state;
	logic [WORD_W-1:0] instr;
	logic [7:0] old_data;
	logic [7:0] new_data;
	logic call_shadow;
	logic [DATA_AW-1:0] eff_addr;
	logic is_invert;
	logic is_bov;
	logic is_bz;
	logic is_call;
	logic take_branch;
	logic [PC_W-1:0] branch_target;
	logic [7:0] instr_hi_k;

	// One mapping for both the read and the write of a toggle
	function automatic logic [DATA_AW-1:0] map_file(input logic [WORD_W-1:0] w,
		input logic [7:0] bank, input logic ext, input logic [DATA_AW-1:0] base);
		logic [7:0] f;
		f = w[7:0];
		if (w[ACCESS_POS])
			map_file = {bank[3:0], f};
		else if (ext && f <= INDEXED_LIMIT)
			map_file = base + {4'h0, f};
		else if (f < ACCESS_SPLIT)
			map_file = {ACCESS_LOW_BANK, f};
		else
			map_file = {ACCESS_HIGH_BANK, f};
	endfunction

	always_comb
	begin
		is_invert = (state == ST_EXEC) && (instr[15:12] == OP_BIT_INVERT);
		is_bov = (state == ST_EXEC) && (instr[15:8] == OP_BRANCH_OVF);
		is_bz = (state == ST_EXEC) && (instr[15:8] == OP_BRANCH_ZERO);
		is_call = (state == ST_EXEC) && (instr[15:9] == OP_CALL);
		take_branch = (is_bov && live_regs.flags[OVF_POS]) ||
			(is_bz && live_regs.flags[ZERO_POS]);
		branch_target = pc + PC_STEP + {{12{instr[7]}}, instr[7:0], 1'b0};
		eff_addr = map_file(instr, live_regs.bank_select_reg, ext_enable, index_base);
	end

	// Phase counter, four clocks per instruction cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			phase <= PH_Q1;
		else if (ce)
			phase <= phase + 2'h1;
	end

	// Decode latch; a flush cycle ignores the word on the bus
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			instr <= '0;
		else if (ce && phase == PH_Q1 && state != ST_FLUSH)
			instr <= instr_word;
	end

	always_ff @(posedge clk)
	begin
		if (ce && load_en)
			general_purpose_file[load_addr] <= load_data;
		else if (ce && phase == PH_Q4 && is_invert)
			general_purpose_file[eff_addr] <= new_data;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			old_data <= 8'h00;
			new_data <= 8'h00;
		end
		else if (ce && phase == PH_Q2)
			old_data <= general_purpose_file[eff_addr];
		else if (ce && phase == PH_Q3)
			new_data <= old_data ^ (8'h01 << instr[BIT_SEL_HI:BIT_SEL_LO]);
	end

	// Write strobe stands through the following Q1
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			file_we <= 1'b0;
			file_addr <= '0;
			file_wdata <= 8'h00;
		end
		else if (ce)
		begin
			file_we <= (phase == PH_Q4) && is_invert && !load_en;
			if (phase == PH_Q4 && is_invert)
			begin
				file_addr <= eff_addr;
				file_wdata <= new_data;
			end
		end
	end

	// Sequencer and program counter, both move only at Q4
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= ST_EXEC;
			pc <= PC_RESET;
			call_shadow <= 1'b0;
		end
		else if (ce && phase == PH_Q4)
		begin
			case (state)
				ST_EXEC:
				begin
					if (take_branch)
					begin
						pc <= branch_target;
						state <= ST_FLUSH;
					end
					else if (is_call)
					begin
						pc <= pc + PC_STEP;
						call_shadow <= instr[SHADOW_POS];
						state <= ST_CALL2;
					end
					else
						pc <= pc + PC_STEP;
				end
				ST_FLUSH:
					state <= ST_EXEC;
				ST_CALL2:
				begin
					pc <= {instr[11:0], instr_hi_k, 1'b0};
					state <= ST_EXEC;
				end
				default:
					state <= ST_EXEC;
			endcase
		end
	end

	// Low target byte kept from the first call word
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			instr_hi_k <= 8'h00;
		else if (ce && phase == PH_Q4 && is_call)
			instr_hi_k <= instr[7:0];
	end

	// Push and shadow copy happen with the first word, so the
	// return stack never sees a half-decoded call
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stack_push <= 1'b0;
			stack_addr <= PC_RESET;
			accumulator_shadow <= 8'h00;
			flags_shadow <= 8'h00;
			bank_select_shadow <= 8'h00;
		end
		else if (ce)
		begin
			stack_push <= (phase == PH_Q4) && is_call;
			if (phase == PH_Q4 && is_call)
			begin
				stack_addr <= pc + CALL_RETURN_STEP;
				if (instr[SHADOW_POS])
				begin
					accumulator_shadow <= live_regs.accumulator;
					flags_shadow <= live_regs.flags;
					bank_select_shadow <= live_regs.bank_select_reg;
				end
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	toggle_one_bit_a: assert property (
		file_we |-> $countones(file_wdata ^ old_data) == 1)
		else $error("toggle changed other than one bit");
	access_bank_a: assert property (
		(is_invert && !instr[ACCESS_POS] && !(ext_enable && instr[7:0] <= INDEXED_LIMIT))
		|-> eff_addr[11:8] == (instr[7:0] < ACCESS_SPLIT ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK))
		else $error("access bank address wrong");
	banked_addr_a: assert property (
		(ce && phase == PH_Q4 && is_invert && instr[ACCESS_POS])
		|=> file_addr == {$past(live_regs.bank_select_reg[3:0]), $past(instr[7:0])})
		else $error("banked address wrong");
	indexed_addr_a: assert property (
		(is_invert && !instr[ACCESS_POS] && ext_enable && instr[7:0] <= INDEXED_LIMIT)
		|-> eff_addr == index_base + {4'h0, instr[7:0]})
		else $error("indexed offset address wrong");
	branch_target_a: assert property (
		(ce && phase == PH_Q4 && take_branch)
		|=> pc == $past(pc) + PC_STEP + {{12{$past(instr[7])}}, $past(instr[7:0]), 1'b0}
		&& state == ST_FLUSH)
		else $error("taken branch target wrong");
	branch_skip_a: assert property (
		(ce && phase == PH_Q4 && (is_bov || is_bz) && !take_branch)
		|=> pc == $past(pc) + PC_STEP && state == ST_EXEC)
		else $error("untaken branch misbehaved");
	overflow_cond_a: assert property (
		(ce && phase == PH_Q4 && is_bov && !live_regs.flags[OVF_POS]) |=> state == ST_EXEC)
		else $error("overflow branch taken with flag clear");
	zero_cond_a: assert property (
		(ce && phase == PH_Q4 && is_bz && !live_regs.flags[ZERO_POS]) |=> state == ST_EXEC)
		else $error("zero branch taken with flag clear");
	call_push_a: assert property (
		stack_push |-> stack_addr == pc + PC_STEP && state == ST_CALL2)
		else $error("call return address wrong");
	call_target_a: assert property (
		(ce && phase == PH_Q4 && state == ST_CALL2)
		|=> pc == {$past(instr[11:0]), $past(instr_hi_k), 1'b0} && state == ST_EXEC)
		else $error("call target wrong");
	shadow_hold_a: assert property (
		$changed(accumulator_shadow) |-> $past(is_call && instr[SHADOW_POS]))
		else $error("shadow changed without shadow call");

	invert_c: cover property (file_we);
	branch_taken_c: cover property (ce && phase == PH_Q4 && take_branch);
	branch_skip_c: cover property (ce && phase == PH_Q4 && (is_bov || is_bz) && !take_branch);
	call_shadow_c: cover property (stack_push && call_shadow);

endmodule

`default_nettype wire

// File: dv/exec_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none

module exec_unit_bench
	import exec_pkg::*;
;

logic clk = 1'h0, rstn = 1'h0, ce = 1'h1, ext_enable = 1'h0, load_en = 1'h0;
logic [15:0] instr_word = '0;
core_regs_t live_regs = '0, nregs = '0, sh = '0;
logic [11:0] index_base = 12'h300, load_addr = '0, ld_a = '0, file_addr;
logic [7:0] load_data = '0, ld_d = '0, file_wdata;
logic [7:0] accumulator_shadow, flags_shadow, bank_select_shadow;
logic ld_go = 1'h0, next_ext = 1'h0, file_we, stack_push;
logic we_seen = 1'h0, push_seen = 1'h0;
logic [PC_W-1:0] pc, stack_addr, at = '0, tgt;
logic [1:0] phase;
int bad_count = 0, checks_done = 0, cycles = 0;

exec_unit #(.DATA_AW(12)) exec_unit_inst
(
	.clk, .rstn, .ce, .instr_word, .live_regs, .ext_enable, .index_base,
	.load_en, .load_addr, .load_data, .pc, .phase, .file_we, .file_addr,
	.file_wdata, .stack_push, .stack_addr, .accumulator_shadow,
	.flags_shadow, .bank_select_shadow
);

always #5 clk = ~clk;

// Ceiling well above the 138 cycles the tests need
always @(posedge clk)
begin
	cycles <= cycles + 1;
	if (cycles == 3000)
	begin
		bad_count++;
		end_of_test;
	end
end

task chk(input logic [31:0] s, input logic [31:0] e);
	checks_done++;
	if (s !== e)
	begin
		bad_count++;
		$display("MISMATCH %0t seen %0h expected %0h", $time, s, e);
	end
endtask

// Finishes the running instruction, presents the next word at its Q4 edge.
// Returns just after the Q1 edge, so results of the finished one are settled.
task cyc(input logic [15:0] w);
	@(posedge clk);
	load_en <= ld_go;
	load_addr <= ld_a;
	load_data <= ld_d;
	ld_go = 1'h0;
	@(posedge clk);
	load_en <= 1'h0;
	@(posedge clk);
	instr_word <= w;
	live_regs <= nregs;
	ext_enable <= next_ext;
	// One-clock strobes are gone by the Q1 edge, so catch them here
	#1;
	we_seen = file_we;
	push_seen = stack_push;
	@(posedge clk);
	#1;
endtask

task t_tog;
	logic [15:0] tw [4];
	logic [11:0] ea [4];
	tw = '{16'h7920, 16'h705f, 16'h7e60, 16'h765f};
	ea = '{12'h520, 12'h05f, 12'hf60, 12'h35f};
	for (int i = 0; i < 4; i++)
	begin
		nregs.bank_select_reg = 8'h45;
		next_ext = (i == 3);
		ld_go = 1'h1;
		ld_a = ea[i];
		ld_d = 8'h75;
		at += 2;
		cyc(tw[i]);
		chk(pc, at);
		at += 2;
		cyc('0);
		chk(pc, at);
		chk(we_seen, 1);
		chk(file_addr, ea[i]);
		chk(file_wdata, 8'h75 ^ (8'h01 << tw[i][BIT_SEL_HI:BIT_SEL_LO]));
	end
	next_ext = 1'h0;
	$display("test toggle done");
endtask

task t_br;
	logic [15:0] bw [6];
	logic [7:0] fl [6];
	logic tk;
	bw = '{16'he07f, 16'he080, 16'he480, 16'he47f, 16'he47f, 16'he080};
	fl = '{8'h04, 8'h08, 8'h08, 8'h04, 8'h08, 8'h04};
	for (int i = 0; i < 6; i++)
	begin
		nregs.flags = fl[i];
		at += 2;
		cyc(bw[i]);
		chk(pc, at);
		tk = bw[i][10] ? fl[i][OVF_POS] : fl[i][ZERO_POS];
		tgt = at + 21'h2;
		if (tk)
			tgt = tgt + {{12{bw[i][7]}}, bw[i][7:0], 1'h0};
		// The flush cycle gets a live toggle word: it must not execute
		cyc(tk ? 16'h7920 : 16'h0000);
		chk(pc, tgt);
		at = tgt;
		if (tk)
		begin
			cyc('0);
			chk(pc, at);
			chk(we_seen, 0);
		end
	end
	$display("test branch done");
endtask

task t_call;
	logic [19:0] k;
	for (int s = 1; s >= 0; s--)
	begin
		k = s ? 20'h12345 : 20'h00abc;
		nregs = s ? 24'ha53c0e : 24'h112233;
		if (s)
			sh = nregs;
		at += 2;
		cyc({OP_CALL, s[0], k[7:0]});
		chk(pc, at);
		cyc({4'h0, k[19:8]});
		chk(pc, at + 21'h2);
		chk(push_seen, 1);
		chk(stack_addr, at + 21'h4);
		chk(accumulator_shadow, sh.accumulator);
		chk(flags_shadow, sh.flags);
		chk(bank_select_shadow, sh.bank_select_reg);
		cyc('0);
		at = {k, 1'h0};
		chk(pc, at);
		chk(push_seen, 0);
	end
	$display("test call done");
endtask

// Three frozen edges leave phase and pc behind a free run
task t_hold;
	logic [PC_W-1:0] pc0;
	pc0 = pc;
	@(posedge clk);
	ce <= 1'h0;
	repeat (3) @(posedge clk);
	ce <= 1'h1;
	#1;
	chk(phase, PH_Q3);
	chk(pc, pc0);
	repeat (3) @(posedge clk);
	#1;
	at += 2;
	chk(pc, at);
	$display("test enable done");
endtask

task end_of_test;
	$display("checks %0d mismatches %0d", checks_done, bad_count);
	if (bad_count == 0 && checks_done > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
endtask

initial
begin
	repeat (10) @(posedge clk);
	rstn <= 1'h1;
	@(posedge clk);
	#1;
	chk(pc, 0);
	chk(phase, PH_Q2);
	chk(file_we, 0);
	chk(accumulator_shadow, 0);
	$display("test reset done");
	t_tog;
	t_br;
	t_call;
	t_hold;
	end_of_test;
end

endmodule

`default_nettype wire
